// ===== data_memory_sector_addressing.sv
// Data memory sector decoder with indirect ports and memory pointers.
`timescale 1ns/100ps
// Contract
// - offsets 00H-7FH special, 80H-FFH general RAM.
// - sector 3 offsets 00H-3FH are sine memory.
// - sine memory selected by sector and offset.
// - general RAM in sectors 0-2 or 0-3.
// - every location is eight bits wide.
// - no bank pointer; high pointer gives sector.
// - extended address: sector high, offset low byte.
// - extended direct access reaches every sector.
// - general RAM writable; bit ops touch one bit.
// - unused special locations read zero.
// - protected special registers ignore writes.
// - indirect port acts on pointed location.
// - first indirect port reaches sector 0 only.
// - second and third ports reach any sector.
// - resolved indirect port reads zero, ignores writes.
// - pointers are real readable writable storage.
module data_memory_sector_addressing #(
	parameter int GP_SECTORS = data_memory_pkg::GP_SECTORS_LARGE
) (
	input  wire logic                                   clk_sys,
	input  wire logic                                   reset_n,
	input  wire logic                                   memReq,
	input  wire logic                                   memWrite,
	input  wire logic                                   extendedAccess,
	input  wire logic [data_memory_pkg::ADDR_W-1:0]     memAddr,
	input  wire logic [data_memory_pkg::DATA_W-1:0]     wrData,
	input  wire logic                                   bitOp,
	input  wire logic [data_memory_pkg::BIT_SEL_W-1:0]  bitSel,
	input  wire logic                                   bitValue,
	output logic      [data_memory_pkg::DATA_W-1:0]     rdData,
	output logic                                        rdValid,
	output logic      [data_memory_pkg::SECTOR_W-1:0]   sfrSector,
	output logic      [data_memory_pkg::OFFSET_W-1:0]   sfrOffset,
	output logic                                        sfrWrite,
	output logic      [data_memory_pkg::DATA_W-1:0]     sfrWrData,
	input  wire logic [data_memory_pkg::DATA_W-1:0]     sfrRdData,
	input  wire logic                                   sfrPresent,
	input  wire logic                                   sfrReadOnly
);
	localparam int GP_DEPTH = GP_SECTORS * data_memory_pkg::GP_SECTOR_DEPTH;

	mem_port_if #(.AW(data_memory_pkg::GP_INDEX_W))   gpPort ();
	mem_port_if #(.AW(data_memory_pkg::SINE_INDEX_W)) sinePort ();
	mem_port_if #(.AW(data_memory_pkg::SLOT_W))       ptrPort ();

	logic [data_memory_pkg::POINTER_COUNT-1:0][7:0] pointerValue;

	data_ram_bank #(
		.AW    (data_memory_pkg::GP_INDEX_W),
		.DEPTH (GP_DEPTH)
	) u_gp_ram (
		.clk_sys (clk_sys),
		.port    (gpPort.target)
	);

	data_ram_bank #(
		.AW    (data_memory_pkg::SINE_INDEX_W),
		.DEPTH (data_memory_pkg::SINE_DEPTH)
	) u_sine_ram (
		.clk_sys (clk_sys),
		.port    (sinePort.target)
	);

	pointer_file u_pointers (
		.clk_sys      (clk_sys),
		.reset_n      (reset_n),
		.port         (ptrPort.target),
		.pointerValue (pointerValue)
	);

	// Direct address; standard instructions only see sector 0.
	wire logic [1:0] directSector;
	wire logic [7:0] directOffset;
	assign directSector = extendedAccess ?
		memAddr[data_memory_pkg::ADDR_W-1:data_memory_pkg::OFFSET_W] :
		data_memory_pkg::SECTOR_ZERO;
	assign directOffset = memAddr[data_memory_pkg::OFFSET_W-1:0];

	wire logic directSectorZero;
	wire logic hitPortZero;
	wire logic hitPortOne;
	wire logic hitPortTwo;
	assign directSectorZero = directSector == data_memory_pkg::SECTOR_ZERO;
	assign hitPortZero = directSectorZero &&
		directOffset == data_memory_pkg::OFS_PORT_ZERO;
	assign hitPortOne = directSectorZero &&
		directOffset == data_memory_pkg::OFS_PORT_ONE;
	assign hitPortTwo = directSectorZero &&
		directOffset == data_memory_pkg::OFS_PORT_TWO;

	// There is no bank register; only the low sector bits are looked at.
	wire logic [1:0] sectorOne;
	wire logic [1:0] sectorTwo;
	assign sectorOne =
		pointerValue[data_memory_pkg::SLOT_ONE_SECTOR][1:0];
	assign sectorTwo =
		pointerValue[data_memory_pkg::SLOT_TWO_SECTOR][1:0];

	// Resolved target; a port is replaced by its pointer in the same cycle.
	wire logic [1:0] tgtSector;
	wire logic [7:0] tgtOffset;
	assign tgtSector = hitPortZero ? data_memory_pkg::SECTOR_ZERO :
		hitPortOne ? sectorOne :
		hitPortTwo ? sectorTwo :
		directSector;
	assign tgtOffset =
		hitPortZero ? pointerValue[data_memory_pkg::SLOT_ZERO] :
		hitPortOne ? pointerValue[data_memory_pkg::SLOT_ONE_OFFSET] :
		hitPortTwo ? pointerValue[data_memory_pkg::SLOT_TWO_OFFSET] :
		directOffset;

	wire logic tgtSectorZero;
	wire logic tgtIsPort;
	wire logic tgtGpArea;
	wire logic [2:0] slotSel;
	wire logic slotHit;
	assign tgtSectorZero = tgtSector == data_memory_pkg::SECTOR_ZERO;
	assign tgtIsPort = tgtSectorZero &&
		(tgtOffset == data_memory_pkg::OFS_PORT_ZERO ||
		tgtOffset == data_memory_pkg::OFS_PORT_ONE ||
		tgtOffset == data_memory_pkg::OFS_PORT_TWO);
	assign tgtGpArea = tgtOffset >= data_memory_pkg::GP_BASE;
	assign slotSel =
		(tgtOffset == data_memory_pkg::OFS_POINTER_ZERO) ?
			data_memory_pkg::SLOT_ZERO :
		(tgtOffset == data_memory_pkg::OFS_POINTER_ONE_OFFSET) ?
			data_memory_pkg::SLOT_ONE_OFFSET :
		(tgtOffset == data_memory_pkg::OFS_POINTER_ONE_SECTOR) ?
			data_memory_pkg::SLOT_ONE_SECTOR :
		(tgtOffset == data_memory_pkg::OFS_POINTER_TWO_OFFSET) ?
			data_memory_pkg::SLOT_TWO_OFFSET :
			data_memory_pkg::SLOT_TWO_SECTOR;
	assign slotHit = tgtOffset == data_memory_pkg::OFS_POINTER_ZERO ||
		tgtOffset == data_memory_pkg::OFS_POINTER_ONE_OFFSET ||
		tgtOffset == data_memory_pkg::OFS_POINTER_ONE_SECTOR ||
		tgtOffset == data_memory_pkg::OFS_POINTER_TWO_OFFSET ||
		tgtOffset == data_memory_pkg::OFS_POINTER_TWO_SECTOR;

	wire logic selGp;
	wire logic selSine;
	wire logic selPointer;
	wire logic selSfr;
	assign selGp = tgtGpArea &&
		32'(tgtSector) < GP_SECTORS;
	assign selSine = !tgtGpArea &&
		tgtSector == data_memory_pkg::SINE_SECTOR &&
		tgtOffset < data_memory_pkg::SINE_LIMIT;
	assign selPointer = tgtSectorZero && slotHit;
	assign selSfr = !tgtGpArea && !tgtIsPort && !selPointer &&
		tgtSector <= data_memory_pkg::LAST_SFR_SECTOR;

	data_memory_pkg::target_t target;
	assign target = selGp ? data_memory_pkg::TGT_GP :
		selSine ? data_memory_pkg::TGT_SINE :
		selPointer ? data_memory_pkg::TGT_POINTER :
		selSfr ? data_memory_pkg::TGT_SFR :
		data_memory_pkg::TGT_NONE;

	// Holes, ports and unpopulated sectors all fall through to zero.
	logic [7:0] curValue;
	always_comb begin
		case (target)
			data_memory_pkg::TGT_GP:      curValue = gpPort.rdData;
			data_memory_pkg::TGT_SINE:    curValue = sinePort.rdData;
			data_memory_pkg::TGT_POINTER: curValue = ptrPort.rdData;
			data_memory_pkg::TGT_SFR:     curValue = sfrPresent ?
				sfrRdData : data_memory_pkg::READ_ZERO;
			default:                      curValue =
				data_memory_pkg::READ_ZERO;
		endcase
	end

	// Bit operations merge one bit into the current content.
	wire logic [7:0] bitMask;
	wire logic [7:0] storeValue;
	wire logic doWrite;
	assign bitMask = data_memory_pkg::BIT_ONE << bitSel;
	assign storeValue = !bitOp ? wrData :
		bitValue ? (curValue | bitMask) : (curValue & ~bitMask);
	assign doWrite = memReq && memWrite;

	assign gpPort.addr = {tgtSector, tgtOffset[6:0]};
	assign gpPort.wrData = storeValue;
	assign gpPort.wrEn = doWrite && selGp;
	assign sinePort.addr = tgtOffset[data_memory_pkg::SINE_INDEX_W-1:0];
	assign sinePort.wrData = storeValue;
	assign sinePort.wrEn = doWrite && selSine;
	assign ptrPort.addr = slotSel;
	assign ptrPort.wrData = storeValue;
	assign ptrPort.wrEn = doWrite && selPointer;

	// The special register port sees the resolved address, even a port, but a port never gets a write strobe.
	assign sfrSector = tgtSector;
	assign sfrOffset = tgtOffset;
	assign sfrWrData = storeValue;
	assign sfrWrite = doWrite && selSfr &&
		sfrPresent && !sfrReadOnly;

	logic [7:0] rdData_r;
	logic [7:0] rdData_nxt;
	logic       rdValid_r;
	wire logic  readReq;
	assign readReq = memReq && !memWrite;
	assign rdData_nxt = readReq ? curValue : rdData_r;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rdData_r <= data_memory_pkg::READ_ZERO;
			rdValid_r <= 1'b0;
		end else begin
			rdData_r <= rdData_nxt;
			rdValid_r <= readReq;
		end
	end

	assign rdData = rdData_r;
	assign rdValid = rdValid_r;

	// Checks below hold the decoder to its intended behaviour.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	sequence s_read_req;
		memReq && !memWrite;
	endsequence

	sequence s_answer_zero;
		rdValid && rdData == 8'h00;
	endsequence

	property p_read_latency;
		s_read_req |=> rdValid ##1 !$past(readReq) || rdValid;
	endproperty
	a_read_latency: assert property (p_read_latency)
		else $error("read answer missing one cycle after request");

	property p_port_reads_zero;
		s_read_req and (tgtIsPort) |=> s_answer_zero;
	endproperty
	a_port_reads_zero: assert property (p_port_reads_zero)
		else $error("resolved indirect port did not read zero");

	property p_missing_sector_zero;
		s_read_req and (tgtGpArea && 32'(tgtSector) >= GP_SECTORS)
			|=> s_answer_zero;
	endproperty
	a_missing_sector_zero: assert property (p_missing_sector_zero)
		else $error("unpopulated general sector did not read zero");

	property p_unused_sfr_zero;
		s_read_req and (selSfr && !sfrPresent) |=> s_answer_zero;
	endproperty
	a_unused_sfr_zero: assert property (p_unused_sfr_zero)
		else $error("unused special location did not read zero");

	property p_protected_kept;
		sfrWrite |-> !sfrReadOnly && sfrPresent && !tgtIsPort;
	endproperty
	a_protected_kept: assert property (p_protected_kept)
		else $error("write reached a protected special register");

	property p_port_zero_sector;
		memReq && hitPortZero |-> tgtSector == 2'h0 &&
			tgtOffset == pointerValue[0];
	endproperty
	a_port_zero_sector: assert property (p_port_zero_sector)
		else $error("first indirect port left sector 0");

	property p_port_one_sector;
		memReq && hitPortOne |-> tgtSector == pointerValue[2][1:0] &&
			tgtOffset == pointerValue[1];
	endproperty
	a_port_one_sector: assert property (p_port_one_sector)
		else $error("second indirect port resolved wrongly");

	property p_extended_sector;
		memReq && !hitPortZero && !hitPortOne && !hitPortTwo |->
			tgtSector == (extendedAccess ? memAddr[9:8] : 2'h0);
	endproperty
	a_extended_sector: assert property (p_extended_sector)
		else $error("direct address sector decoded wrongly");

	property p_pointer_store;
		doWrite && selPointer && !bitOp && slotSel == 3'h0 |=>
			pointerValue[0] == $past(wrData);
	endproperty
	a_pointer_store: assert property (p_pointer_store)
		else $error("pointer register did not take written value");

	property p_bit_op_isolated;
		doWrite && bitOp |-> ((storeValue ^ curValue) & ~bitMask) == 8'h00
			&& storeValue[bitSel] == bitValue;
	endproperty
	a_bit_op_isolated: assert property (p_bit_op_isolated)
		else $error("bit operation disturbed another bit");

	property p_sine_select;
		memReq && tgtSector == 2'h3 && tgtOffset < 8'h40 |->
			target == data_memory_pkg::TGT_SINE;
	endproperty
	a_sine_select: assert property (p_sine_select)
		else $error("sine area not selected in sector 3");
endmodule : data_memory_sector_addressing

// ===== data_memory_pkg.sv
// Shared constants and types for the data memory sector decoder.
package data_memory_pkg;

	localparam int DATA_W           = 8;
	localparam int SECTOR_W         = 2;
	localparam int OFFSET_W         = 8;
	localparam int ADDR_W           = 10;
	localparam int BIT_SEL_W        = 3;
	localparam int GP_SECTOR_DEPTH  = 128;
	localparam int GP_INDEX_W       = 9;
	localparam int GP_SECTORS_SMALL = 3;
	localparam int GP_SECTORS_LARGE = 4;
	localparam int SINE_DEPTH       = 64;
	localparam int SINE_INDEX_W     = 6;
	localparam int POINTER_COUNT    = 5;
	localparam int SLOT_W           = 3;

	localparam logic [7:0] OFS_PORT_ZERO          = 8'h00;
	localparam logic [7:0] OFS_POINTER_ZERO       = 8'h01;
	localparam logic [7:0] OFS_PORT_ONE           = 8'h02;
	localparam logic [7:0] OFS_POINTER_ONE_OFFSET = 8'h03;
	localparam logic [7:0] OFS_POINTER_ONE_SECTOR = 8'h04;
	localparam logic [7:0] OFS_PORT_TWO           = 8'h0C;
	localparam logic [7:0] OFS_POINTER_TWO_OFFSET = 8'h0D;
	localparam logic [7:0] OFS_POINTER_TWO_SECTOR = 8'h0E;

	localparam logic [7:0] GP_BASE       = 8'h80;
	localparam logic [7:0] SINE_LIMIT    = 8'h40;
	localparam logic [7:0] READ_ZERO     = 8'h00;
	localparam logic [7:0] POINTER_RESET = 8'h00;
	localparam logic [7:0] BIT_ONE       = 8'h01;

	localparam logic [1:0] SECTOR_ZERO     = 2'h0;
	localparam logic [1:0] LAST_SFR_SECTOR = 2'h1;
	localparam logic [1:0] SINE_SECTOR     = 2'h3;

	localparam logic [2:0] SLOT_ZERO         = 3'h0;
	localparam logic [2:0] SLOT_ONE_OFFSET   = 3'h1;
	localparam logic [2:0] SLOT_ONE_SECTOR   = 3'h2;
	localparam logic [2:0] SLOT_TWO_OFFSET   = 3'h3;
	localparam logic [2:0] SLOT_TWO_SECTOR   = 3'h4;

	typedef enum logic [2:0] {
		TGT_NONE    = 3'b000,
		TGT_GP      = 3'b001,
		TGT_SINE    = 3'b010,
		TGT_POINTER = 3'b011,
		TGT_SFR     = 3'b100
	} target_t;

endpackage : data_memory_pkg

// ===== mem_port_if.sv
// Access port between the decoder and one of its storage blocks.
`timescale 1ns/100ps
interface mem_port_if #(parameter int AW = 9) ();
	logic [AW-1:0] addr;
	logic          wrEn;
	logic [7:0]    wrData;
	logic [7:0]    rdData;

	modport master (output addr, output wrEn, output wrData, input rdData);
	modport target (input addr, input wrEn, input wrData, output rdData);
endinterface : mem_port_if

// ===== data_ram_bank.sv
// Byte-wide RAM with combinational read and clocked write.
`timescale 1ns/100ps
module data_ram_bank #(
	parameter int AW    = 9,
	parameter int DEPTH = 512
) (
	input  wire logic clk_sys,
	mem_port_if.target port
);
	logic [7:0] mem [DEPTH];

	// The read is combinational so a bit operation can merge in one cycle.
	always_ff @(posedge clk_sys) begin
		if (port.wrEn) begin
			mem[port.addr] <= port.wrData;
		end
	end

	assign port.rdData = mem[port.addr];
endmodule : data_ram_bank

// ===== pointer_file.sv
// The five memory pointer registers, held as real storage.
`timescale 1ns/100ps
module pointer_file (
	input  wire logic clk_sys,
	input  wire logic reset_n,
	mem_port_if.target port,
	output logic [data_memory_pkg::POINTER_COUNT-1:0][7:0] pointerValue
);
	genvar i;
	generate
		for (i = 0; i < data_memory_pkg::POINTER_COUNT; i++) begin : g_ptr
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					pointerValue[i] <= data_memory_pkg::POINTER_RESET;
				end else if (port.wrEn &&
						port.addr == data_memory_pkg::SLOT_W'(i)) begin
					pointerValue[i] <= port.wrData;
				end
			end
		end
	endgenerate

	assign port.rdData = (port.addr < data_memory_pkg::SLOT_W'(
		data_memory_pkg::POINTER_COUNT)) ? pointerValue[port.addr] :
		data_memory_pkg::READ_ZERO;
endmodule : pointer_file

// ===== sfr_model.sv
// Behavioural special register set on the decoder's register port.
`timescale 1ns/100ps
module sfr_model (
	input  wire logic       clk_sys,
	input  wire logic [1:0] sfrSector,
	input  wire logic [7:0] sfrOffset,
	input  wire logic       sfrWrite,
	input  wire logic [7:0] sfrWrData,
	input  wire logic       sfrPresent,
	output logic      [7:0] sfrRdData
);
	logic      [7:0] mem [256];
	logic      [7:0] last_r;
	wire logic [7:0] idx = {sfrSector[0], sfrOffset[6:0]};
	// Absent locations show a changing pattern, so a leak through is seen.
	assign sfrRdData = sfrPresent ? mem[idx] : ~last_r;
	initial begin
		last_r = 8'h00;
		for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
	end
	// Any strobe is stored, protected or not, so a stray strobe corrupts.
	always @(posedge clk_sys) begin
		last_r <= sfrRdData;
		if (sfrWrite) mem[idx] <= sfrWrData;
	end
endmodule : sfr_model

// ===== data_memory_sector_addressing_bench.sv
// Self-checking bench for the data memory sector decoder.
`timescale 1ns/100ps
module data_memory_sector_addressing_bench;
	localparam int GPS = data_memory_pkg::GP_SECTORS_SMALL;
	logic clk_sys = 1'b0, reset_n = 1'b0, memReq = 1'b0, memWrite = 1'b0;
	logic extendedAccess = 1'b0, bitOp = 1'b0, bitValue = 1'b0;
	logic [9:0] memAddr = 10'h000;
	logic [7:0] wrData = 8'h00;
	logic [2:0] bitSel = 3'h0;
	logic [7:0] rdData, sfrOffset, sfrWrData, sfrRdData;
	logic [1:0] sfrSector;
	logic       rdValid, sfrWrite, sfrPresent, sfrReadOnly;
	logic [7:0] gp [512];
	logic [7:0] sine [64];
	logic [7:0] ptr [5];
	logic [7:0] sref [256];
	logic [31:0] seed_r = 32'hC48F2A71;
	// Last value a read returned; the registered read data must hold it.
	logic [7:0] lastRd = 8'h00;
	logic [24:0] corner [18];
	int bad_count = 0, checks = 0;
	function automatic logic pres(input logic [7:0] o);
		return o[3:0] != 4'hB;
	endfunction : pres
	function automatic logic prot(input logic [7:0] o);
		return o[3:0] == 4'h7;
	endfunction : prot
	function automatic logic [31:0] rnd();
		seed_r = seed_r ^ (seed_r << 13);
		seed_r = seed_r ^ (seed_r >> 17);
		seed_r = seed_r ^ (seed_r << 5);
		return seed_r;
	endfunction : rnd
	assign sfrPresent  = pres(sfrOffset);
	assign sfrReadOnly = prot(sfrOffset);
	always #25 clk_sys = ~clk_sys;
	data_memory_sector_addressing #(
		.GP_SECTORS(GPS)
	) u_data_memory_sector_addressing (
		.clk_sys(clk_sys), .reset_n(reset_n), .memReq(memReq),
		.memWrite(memWrite), .extendedAccess(extendedAccess),
		.memAddr(memAddr), .wrData(wrData), .bitOp(bitOp), .bitSel(bitSel),
		.bitValue(bitValue), .rdData(rdData), .rdValid(rdValid),
		.sfrSector(sfrSector), .sfrOffset(sfrOffset), .sfrWrite(sfrWrite),
		.sfrWrData(sfrWrData), .sfrRdData(sfrRdData),
		.sfrPresent(sfrPresent), .sfrReadOnly(sfrReadOnly));
	sfr_model u_sfr_model (
		.clk_sys(clk_sys), .sfrSector(sfrSector), .sfrOffset(sfrOffset),
		.sfrWrite(sfrWrite), .sfrWrData(sfrWrData), .sfrPresent(sfrPresent),
		.sfrRdData(sfrRdData));
	task automatic check(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic summarize();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : summarize
	// Leaves the request raised so accesses can run back to back.
	task automatic acc(input logic w, input logic e, input logic [9:0] a,
		input logic [7:0] d, input logic b, input logic [2:0] bs,
		input logic bv);
		logic [1:0] s;
		logic [7:0] o, cur, nv;
		int k, pi;
		logic ew;
		s = e ? a[9:8] : 2'h0;
		o = a[7:0];
		if (s == 2'h0 && o == 8'h00) o = ptr[0];
		else if (s == 2'h0 && o == 8'h02) {s, o} = {ptr[2][1:0], ptr[1]};
		else if (s == 2'h0 && o == 8'h0C) {s, o} = {ptr[4][1:0], ptr[3]};
		pi = (o == 8'h01) ? 0 : (o == 8'h03) ? 1 : (o == 8'h04) ? 2 :
			(o == 8'h0D) ? 3 : (o == 8'h0E) ? 4 : -1;
		if (o >= 8'h80) k = (s < GPS) ? 1 : 0;
		else if (s == 2'h3 && o < 8'h40) k = 2;
		else if (s == 2'h0 && pi >= 0) k = 3;
		else if (s == 2'h0 && (o == 8'h00 || o == 8'h02 || o == 8'h0C)) k = 0;
		else if (s <= 2'h1 && pres(o)) k = 4;
		else k = 0;
		cur = (k == 1) ? gp[{s, o[6:0]}] : (k == 2) ? sine[o[5:0]] :
			(k == 3) ? ptr[pi] : (k == 4) ? sref[{s[0], o[6:0]}] : 8'h00;
		nv = d;
		if (b) nv[bs] = bv;
		if (b) nv = cur;
		if (b) nv[bs] = bv;
		{memReq, memWrite, extendedAccess, memAddr} = {1'b1, w, e, a};
		{wrData, bitOp, bitSel, bitValue} = {d, b, bs, bv};
		ew = w && k == 4 && !prot(o);
		#1;
		check("sfrSector", {6'h00, sfrSector}, {6'h00, s});
		check("sfrOffset", sfrOffset, o);
		check("sfrWrite", {7'h00, sfrWrite}, {7'h00, ew});
		if (ew) check("sfrWrData", sfrWrData, nv);
		@(posedge clk_sys);
		#1;
		if (w) begin
			check("rdValid", {7'h00, rdValid}, 8'h00);
			check("rdData", rdData, lastRd);
			case (k)
				1: gp[{s, o[6:0]}] = nv;
				2: sine[o[5:0]] = nv;
				3: ptr[pi] = nv;
				4: if (!prot(o)) sref[{s[0], o[6:0]}] = nv;
				default: ;
			endcase
		end else begin
			check("rdValid", {7'h00, rdValid}, 8'h01);
			check("rdData", rdData, cur);
			lastRd = cur;
		end
	endtask : acc
	task automatic idle();
		memReq = 1'b0;
		@(posedge clk_sys);
		#1;
		check("rdValid", {7'h00, rdValid}, 8'h00);
		check("rdData", rdData, lastRd);
	endtask : idle
	initial begin
		#(50 * 90000);
		bad_count++;
		summarize();
	end
	initial begin
		logic [31:0] r;
		// Fields: write, extended, bit op, bit number, bit value, address, data.
		corner = '{25'h0002100, 25'h0006100, 25'h0008100, 25'h001A100,
			25'h001C100, 25'h1000202, 25'h0000000, 25'h10000FF, 25'h1000402,
			25'h1000AFE, 25'h1000690, 25'h100045A, 25'h0D2905A, 25'h0C3A000,
			25'h0000B00, 25'h1000E55, 25'h0000E00, 25'h1F00200};
		for (int i = 0; i < 5; i++) ptr[i] = 8'h00;
		for (int i = 0; i < 256; i++) sref[i] = 8'(i) ^ 8'h5A;
		repeat (4) @(posedge clk_sys);
		#1;
		reset_n = 1'b1;
		for (int i = 0; i < 512; i++)
			acc(1'b1, 1'b1, {i[8:7], 1'b1, i[6:0]}, 8'(rnd() >> 24),
				1'b0, 3'h0, 1'b0);
		for (int i = 0; i < 64; i++)
			acc(1'b1, 1'b1, {4'hC, i[5:0]}, 8'(rnd() >> 24),
				1'b0, 3'h0, 1'b0);
		idle();
		for (int i = 0; i < 18; i++) begin
			r = {7'h00, corner[i]};
			acc(r[24], r[23], r[17:8], r[7:0], r[22], r[21:19], r[18]);
		end
		acc(1'b1, 1'b0, 10'h001, 8'h85, 1'b0, 3'h0, 1'b0);
		acc(1'b1, 1'b0, 10'h000, 8'h00, 1'b1, 3'h7, 1'b0);
		acc(1'b0, 1'b0, 10'h000, 8'h00, 1'b0, 3'h0, 1'b0);
		idle();
		for (int i = 0; i < 4000; i++) begin
			r = rnd();
			acc(r[0], r[1], r[13:4], r[21:14], r[2] & r[0], r[24:22], r[25]);
			if (r[31:29] == 3'h0) idle();
		end
		idle();
		summarize();
	end
endmodule : data_memory_sector_addressing_bench
